// File: rtl/vsca_pkg.sv
// Package: register map, field layout and reset values of the scaler block
// Functional notes
// - Horizontal ratio is 24 bits over three byte registers, (ratio-1)*2^20.
// - Luma low-pass select: 00 auto, 01 CIF, 10 QCIF, 11 icon; resets auto.
// - Vertical factor is 13 bits: eight low bits, five high bits.
// - Interlace flag set alternates initial vertical phase per field.
// - Tap select 000=2, 001=3, 010=4, 011=5 taps.
// - Line-average disable 0 blends adjacent PAL lines; 1 passes lines.
// - U chroma multiplied by gain/128; reset 0x80 is unity.
// - V chroma multiplied by its own gain/128; reset 0x80 is unity.
// - Hue rotates chroma 0.35 degrees per signed step, reset zero.
// - Hue rotation applies to NTSC and PAL, never SECAM.
// - Chroma low-pass enable filters chroma after the comb.
// - Chroma delay signed -2..+2 pixels; other codes give zero delay.
// - Chroma coring select: none, +-7, +-15, +-31.
package vsca_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_HRATIO0  = 12'h418;
  localparam logic [11:0] IDX_HRATIO1  = 12'h419;
  localparam logic [11:0] IDX_HRATIO2  = 12'h41a;
  localparam logic [11:0] IDX_LUMA_LOWPASS_SELECT    = 12'h41b;
  localparam logic [11:0] IDX_VFACT_LO = 12'h41c;
  localparam logic [11:0] IDX_VFACT_HI = 12'h41d;
  localparam logic [11:0] IDX_VERTICAL_TAP_SELECT    = 12'h41e;
  localparam logic [11:0] IDX_LINEAVG  = 12'h41f;
  localparam logic [11:0] IDX_UGAIN    = 12'h420;
  localparam logic [11:0] IDX_VGAIN    = 12'h421;
  localparam logic [11:0] IDX_HUE      = 12'h422;
  localparam logic [11:0] IDX_CCTL     = 12'h423;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h80;

  // Field positions
  localparam int VF_INTERLACE_BIT = 3;
  localparam int CC_LPF_BIT       = 5;
  localparam int CC_DELAY_LSB     = 2;
  localparam int VF_HI_BITS       = 5;

  // Input video standard codes
  localparam logic [1:0] STD_NTSC  = 2'h0;
  localparam logic [1:0] STD_PAL   = 2'h1;
  localparam logic [1:0] STD_SECAM = 2'h2;

  // Hue step of 0.35 degrees in Q12 radians: 0.35*pi/180*4096
  localparam int HUE_STEP_Q12 = 25;
  localparam logic [13:0] ONE_Q12 = 14'h1000;

  // Coring thresholds
  localparam logic [7:0] CORE_T1 = 8'h07;
  localparam logic [7:0] CORE_T2 = 8'h0f;
  localparam logic [7:0] CORE_T3 = 8'h1f;

  localparam int FIFO_DEPTH = 2;
endpackage

// File: rtl/vsca_top.sv
// Scaler control, chroma adjust path and APB register file
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module vsca_top #(
  parameter int MAX_WIDTH = 1024,
  parameter int COL_W     = 10
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Scaler settings toward the scaling core
  output logic      [23:0] horiz_ratio,
  output logic      [1:0]  luma_lowpass_select,
  output logic      [12:0] vert_factor,
  output logic      [2:0]  vertical_tap_count,
  output logic             vert_phase_odd,
  input  wire logic        field_odd,
  input  wire logic [1:0]  video_std,
  // Pixel stream in from the decoder core
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic        in_line_start,
  input  wire logic [7:0]  in_luma,
  input  wire logic [7:0]  in_u,
  input  wire logic [7:0]  in_v,
  // Pixel stream out to the formatter
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [7:0]  out_luma,
  output logic      [7:0]  out_u,
  output logic      [7:0]  out_v
);

  // Register state
  logic [7:0] horiz_ratio_byte0;
  logic [7:0] horiz_ratio_byte1;
  logic [7:0] horiz_ratio_byte2;
  logic [1:0] horiz_filter_control;
  logic [7:0] vert_factor_lower;
  logic [4:0] vert_factor_upper;
  logic [3:0] vert_filter_control;
  logic       line_averaging_control;
  logic [7:0] u_chroma_gain;
  logic [7:0] v_chroma_gain;
  logic [7:0] subcarrier_phase_adjust;
  logic [5:0] chroma_path_control;

  logic        interlaced_phase_alternate;
  logic [2:0]  vertical_tap_select;
  logic        pal_line_blend_disable;
  logic        chroma_lowpass_on;
  logic [2:0]  chroma_pixel_delay;
  logic [1:0]  chroma_core_select;

  assign interlaced_phase_alternate =
    vert_filter_control[vsca_pkg::VF_INTERLACE_BIT];
  assign vertical_tap_select    = vert_filter_control[2:0];
  assign pal_line_blend_disable = line_averaging_control;
  assign chroma_lowpass_on  = chroma_path_control[vsca_pkg::CC_LPF_BIT];
  assign chroma_pixel_delay =
    chroma_path_control[vsca_pkg::CC_DELAY_LSB +: 3];
  assign chroma_core_select = chroma_path_control[1:0];

  function automatic logic signed [7:0] clamp8(
    input logic signed [23:0] x
  );
    if (x > 24'sd127)
      clamp8 = 8'sh7f;
    else if (x < -24'sd128)
      clamp8 = 8'sh80;
    else
      clamp8 = x[7:0];
  endfunction

  // Coring: small chroma is noise, force it to zero
  function automatic logic signed [7:0] core(
    input logic signed [7:0] x,
    input logic [1:0]        sel
  );
    logic [7:0] mag;
    logic [7:0] thr;
    mag = x[7] ? 8'(-x) : 8'(x);
    case (sel)
      2'h1:    thr = vsca_pkg::CORE_T1;
      2'h2:    thr = vsca_pkg::CORE_T2;
      2'h3:    thr = vsca_pkg::CORE_T3;
      default: thr = 8'h00;
    endcase
    core = (sel != 2'h0 && mag <= thr) ? 8'sh00 : x;
  endfunction

  // Gain of g/128 with saturation at the signed range
  function automatic logic signed [7:0] gain(
    input logic signed [7:0] x,
    input logic [7:0]        g
  );
    logic signed [17:0] p;
    p = x * $signed({1'b0, g});
    gain = clamp8(24'(p >>> 7));
  endfunction

  // Chroma tap index: luma sits at tap 2, chroma at tap 2 + delay
  function automatic logic [2:0] delay_tap(input logic [2:0] code);
    case (code)
      3'h6:    delay_tap = 3'h0;
      3'h7:    delay_tap = 3'h1;
      3'h1:    delay_tap = 3'h3;
      3'h2:    delay_tap = 3'h4;
      default: delay_tap = 3'h2;
    endcase
  endfunction

  function automatic logic [7:0] avg_s(
    input logic [7:0] a,
    input logic [7:0] b
  );
    logic signed [8:0] s;
    s = $signed({a[7], a}) + $signed({b[7], b});
    avg_s = s[8:1];
  endfunction

  // APB slave, zero wait states
  logic        setup_ph;
  logic        write_acc;
  logic [11:0] idx;
  logic        idx_hit;
  logic [7:0]  rd_byte;

  assign setup_ph  = psel && !penable;
  assign write_acc = psel && penable && pwrite && !pslverr;
  assign idx       = paddr[13:2];
  assign pready    = 1'b1;

  always_comb begin
    idx_hit = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      vsca_pkg::IDX_HRATIO0:  rd_byte = horiz_ratio_byte0;
      vsca_pkg::IDX_HRATIO1:  rd_byte = horiz_ratio_byte1;
      vsca_pkg::IDX_HRATIO2:  rd_byte = horiz_ratio_byte2;
      vsca_pkg::IDX_LUMA_LOWPASS_SELECT:    rd_byte = {6'h00, horiz_filter_control};
      vsca_pkg::IDX_VFACT_LO: rd_byte = vert_factor_lower;
      vsca_pkg::IDX_VFACT_HI: rd_byte = {3'h0, vert_factor_upper};
      vsca_pkg::IDX_VERTICAL_TAP_SELECT:    rd_byte = {4'h0, vert_filter_control};
      vsca_pkg::IDX_LINEAVG:  rd_byte = {7'h00, line_averaging_control};
      vsca_pkg::IDX_UGAIN:    rd_byte = u_chroma_gain;
      vsca_pkg::IDX_VGAIN:    rd_byte = v_chroma_gain;
      vsca_pkg::IDX_HUE:      rd_byte = subcarrier_phase_adjust;
      vsca_pkg::IDX_CCTL:     rd_byte = {2'h0, chroma_path_control};
      default:                idx_hit = 1'b0;
    endcase
    if (paddr[15:14] != 2'h0 || paddr[1:0] != 2'h0)
      idx_hit = 1'b0;
  end

  // Read data and error latched in setup, stable through access
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en && setup_ph) begin
      prdata  <= {24'h00_0000, rd_byte};
      pslverr <= !idx_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      horiz_ratio_byte0       <= vsca_pkg::RST_BYTE;
      horiz_ratio_byte1       <= vsca_pkg::RST_BYTE;
      horiz_ratio_byte2       <= vsca_pkg::RST_BYTE;
      horiz_filter_control    <= 2'h0;
      vert_factor_lower       <= vsca_pkg::RST_BYTE;
      vert_factor_upper       <= 5'h00;
      vert_filter_control     <= 4'h0;
      line_averaging_control  <= 1'b0;
      u_chroma_gain           <= vsca_pkg::RST_GAIN;
      v_chroma_gain           <= vsca_pkg::RST_GAIN;
      subcarrier_phase_adjust <= vsca_pkg::RST_BYTE;
      chroma_path_control     <= 6'h00;
    end else if (clk_en && write_acc) begin
      case (idx)
        vsca_pkg::IDX_HRATIO0:  horiz_ratio_byte0 <= pwdata[7:0];
        vsca_pkg::IDX_HRATIO1:  horiz_ratio_byte1 <= pwdata[7:0];
        vsca_pkg::IDX_HRATIO2:  horiz_ratio_byte2 <= pwdata[7:0];
        vsca_pkg::IDX_LUMA_LOWPASS_SELECT:    horiz_filter_control <= pwdata[1:0];
        vsca_pkg::IDX_VFACT_LO: vert_factor_lower <= pwdata[7:0];
        vsca_pkg::IDX_VFACT_HI: vert_factor_upper <= pwdata[4:0];
        vsca_pkg::IDX_VERTICAL_TAP_SELECT:    vert_filter_control <= pwdata[3:0];
        vsca_pkg::IDX_LINEAVG:  line_averaging_control <= pwdata[0];
        vsca_pkg::IDX_UGAIN:    u_chroma_gain <= pwdata[7:0];
        vsca_pkg::IDX_VGAIN:    v_chroma_gain <= pwdata[7:0];
        vsca_pkg::IDX_HUE:      subcarrier_phase_adjust <= pwdata[7:0];
        vsca_pkg::IDX_CCTL:     chroma_path_control <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Scaler settings; tap choice vs. width is software's job
  assign horiz_ratio = {horiz_ratio_byte2, horiz_ratio_byte1,
                        horiz_ratio_byte0};
  assign luma_lowpass_select = horiz_filter_control;
  assign vert_factor = {vert_factor_upper, vert_factor_lower};

  always_ff @(posedge clk_sys) begin
    if (reset)
      vertical_tap_count <= 3'h2;
    else if (clk_en) begin
      case (vertical_tap_select)
        3'h1:    vertical_tap_count <= 3'h3;
        3'h2:    vertical_tap_count <= 3'h4;
        3'h3:    vertical_tap_count <= 3'h5;
        default: vertical_tap_count <= 3'h2;
      endcase
    end
  end

  // Initial phase follows field parity only when interlacing
  always_ff @(posedge clk_sys) begin
    if (reset)
      vert_phase_odd <= 1'b0;
    else if (clk_en)
      vert_phase_odd <= interlaced_phase_alternate && field_odd;
  end

  // Pixel history for chroma/luma alignment and low-pass
  logic [7:0] hist_l [2];
  logic [7:0] hist_u [5];
  logic [7:0] hist_v [5];
  logic [7:0] tap_l  [3];
  logic [7:0] tap_u  [6];
  logic [7:0] tap_v  [6];
  logic       push;
  logic       pop;
  logic [1:0] fill;

  assign in_ready = (fill != 2'(vsca_pkg::FIFO_DEPTH));
  assign push     = clk_en && in_valid && in_ready;

  always_comb begin
    tap_l[0] = in_luma;
    tap_u[0] = in_u;
    tap_v[0] = in_v;
    for (int i = 1; i < 3; i++)
      tap_l[i] = hist_l[i-1];
    for (int i = 1; i < 6; i++) begin
      tap_u[i] = hist_u[i-1];
      tap_v[i] = hist_v[i-1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < 2; i++)
        hist_l[i] <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        hist_u[i] <= 8'h00;
        hist_v[i] <= 8'h00;
      end
    end else if (push) begin
      for (int i = 0; i < 2; i++)
        hist_l[i] <= tap_l[i];
      for (int i = 0; i < 5; i++) begin
        hist_u[i] <= tap_u[i];
        hist_v[i] <= tap_v[i];
      end
    end
  end

  // Chroma processing chain
  logic [2:0]         ck;
  logic signed [7:0]  cu;
  logic signed [7:0]  cv;
  logic signed [7:0]  su;
  logic signed [7:0]  sv;
  logic signed [15:0] th;
  logic signed [15:0] cs;
  logic signed [31:0] th2;
  logic signed [23:0] ru;
  logic signed [23:0] rv;
  logic signed [7:0]  hu;
  logic signed [7:0]  hv;
  logic [7:0]         pix_u;
  logic [7:0]         pix_v;

  always_comb begin
    ck = delay_tap(chroma_pixel_delay);
    cu = $signed(tap_u[ck]);
    cv = $signed(tap_v[ck]);
    if (chroma_lowpass_on) begin
      // Two-tap average over the aligned sample and its predecessor
      cu = $signed(avg_s(tap_u[ck], tap_u[3'(ck + 3'h1)]));
      cv = $signed(avg_s(tap_v[ck], tap_v[3'(ck + 3'h1)]));
    end
    su = gain(cu, u_chroma_gain);
    sv = gain(cv, v_chroma_gain);
    // Small-angle rotation: sin ~ a, cos ~ 1 - a^2/2, Q12
    th = 16'($signed(subcarrier_phase_adjust) * vsca_pkg::HUE_STEP_Q12);
    // Square kept at full width; a 16-bit product overflows at large hue
    th2 = th * th;
    cs = 16'($signed({18'h0, vsca_pkg::ONE_Q12}) - (th2 >>> 13));
    ru = (su * cs - sv * th) >>> 12;
    rv = (sv * cs + su * th) >>> 12;
    if (video_std == vsca_pkg::STD_SECAM) begin
      hu = su;
      hv = sv;
    end else begin
      hu = clamp8(ru);
      hv = clamp8(rv);
    end
    pix_u = core(hu, chroma_core_select);
    pix_v = core(hv, chroma_core_select);
  end

  // PAL line blending against the previous line's pixel
  logic [23:0]      line_mem [MAX_WIDTH];
  logic [COL_W-1:0] col;
  logic [COL_W-1:0] col_now;
  logic [23:0]      prev_pix;
  logic             blend;
  logic [23:0]      res;

  assign col_now = in_line_start ? '0 : col;
  assign prev_pix = line_mem[col_now];
  assign blend = (video_std == vsca_pkg::STD_PAL) &&
                 !pal_line_blend_disable;

  always_comb begin
    res = {tap_l[2], pix_u, pix_v};
    if (blend) begin
      res[23:16] = 8'(({1'b0, tap_l[2]} + {1'b0, prev_pix[23:16]}) >> 1);
      res[15:8]  = avg_s(pix_u, prev_pix[15:8]);
      res[7:0]   = avg_s(pix_v, prev_pix[7:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset)
      col <= '0;
    else if (push)
      col <= (col_now == COL_W'(MAX_WIDTH - 1)) ? col_now
             : COL_W'(col_now + 1'b1);
  end

  // Unblended pixel is stored so blending never compounds
  always_ff @(posedge clk_sys) begin
    if (push)
      line_mem[col_now] <= {tap_l[2], pix_u, pix_v};
  end

  // Two-entry output buffer; a stalled formatter stalls the input
  logic [23:0] q [vsca_pkg::FIFO_DEPTH];
  logic        wp;
  logic        rp;

  assign out_valid = (fill != 2'h0);
  assign pop       = clk_en && out_valid && out_ready;
  assign out_luma  = q[rp][23:16];
  assign out_u     = q[rp][15:8];
  assign out_v     = q[rp][7:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp   <= 1'b0;
      rp   <= 1'b0;
      fill <= 2'h0;
      for (int i = 0; i < vsca_pkg::FIFO_DEPTH; i++)
        q[i] <= 24'h00_0000;
    end else begin
      if (push) begin
        q[wp] <= res;
        wp    <= !wp;
      end
      if (pop)
        rp <= !rp;
      fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule // vsca_top

// File: tb/vsca_checker.sv
// Port-level assertion checker for the scaler control block
`timescale 1ns/1ps
module vsca_checker (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [23:0] horiz_ratio,
  input wire logic [1:0]  luma_lowpass_select,
  input wire logic [12:0] vert_factor,
  input wire logic [2:0]  vertical_tap_count,
  input wire logic        vert_phase_odd,
  input wire logic        field_odd,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_u
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence wr_acc(logic [15:0] a);
    psel && penable && pwrite && clk_en && paddr == a;
  endsequence
  sequence setup_at(logic [15:0] a);
    psel && !penable && clk_en && paddr == a;
  endsequence

  ready_high_a: assert property (pready)
    else $error("pready dropped");
  ratio_low_a:
    assert property (wr_acc(16'h1060) |=> horiz_ratio[7:0] ==
      $past(pwdata[7:0])) else $error("ratio low byte not taken");
  luma_sel_a:
    assert property (wr_acc(16'h106c) |=> luma_lowpass_select ==
      $past(pwdata[1:0])) else $error("luma filter select wrong");
  vfact_high_a:
    assert property (wr_acc(16'h1074) |=> vert_factor[12:8] ==
      $past(pwdata[4:0])) else $error("vertical factor high wrong");
  reset_vals_a: assert property ($fell(reset) |-> horiz_ratio == 24'h0
    && vert_factor == 13'h0 && luma_lowpass_select == 2'h0
    && vertical_tap_count == 3'h2) else $error("bad value after reset");
  tap_range_a:
    assert property (vertical_tap_count >= 3'h2 &&
      vertical_tap_count <= 3'h5) else $error("tap count out of range");
  phase_even_a:
    assert property (clk_en && !field_odd |=> !vert_phase_odd)
    else $error("phase alternates on even field");
  unmapped_err_a: assert property (setup_at(16'h1090) |=> pslverr
    && prdata == 32'h0) else $error("unmapped access not refused");
  accept_out_a: assert property (in_valid && in_ready && clk_en |=>
    out_valid) else $error("accepted pixel not offered");
  stall_hold_a: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_u)) else $error("stalled word lost");
endmodule // vsca_checker

bind vsca_top vsca_checker u_chk (
  .clk_sys, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .horiz_ratio, .luma_lowpass_select,
  .vert_factor, .vertical_tap_count, .vert_phase_odd, .field_odd,
  .in_valid, .in_ready, .out_valid, .out_ready, .out_u
);

// File: tb/tb_video_scaler_chroma_adjust.sv
// Self-checking bench for the scaler control and chroma path
`timescale 1ns/1ps
module tb_video_scaler_chroma_adjust;
  localparam logic [11:0] B = vsca_pkg::IDX_HRATIO0;
  localparam logic [7:0] MASK [12] = '{8'hff, 8'hff, 8'hff, 8'h03,
    8'hff, 8'h1f, 8'h0f, 8'h01, 8'hff, 8'hff, 8'hff, 8'h3f};
  localparam int THR [4] = '{0, 7, 15, 31};
  logic        clk_sys, reset, clk_en, psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, vert_phase_odd, field_odd;
  logic [23:0] horiz_ratio;
  logic [1:0]  luma_lowpass_select, video_std;
  logic [12:0] vert_factor;
  logic [2:0]  vertical_tap_count;
  logic        in_valid, in_ready, in_line_start, out_valid, out_ready;
  logic [7:0]  in_luma, in_u, in_v, out_luma, out_u, out_v;
  logic [7:0]  hy [64], hu [64], hv [64];
  logic [23:0] exp_q [$], got_q [$];
  int          num_errors, cmp_count, n_in, dly, thr, ug, vg, lp;

  vsca_top dut (
    .clk_sys, .reset, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .horiz_ratio,
    .luma_lowpass_select, .vert_factor, .vertical_tap_count,
    .vert_phase_odd, .field_odd, .video_std, .in_valid, .in_ready,
    .in_line_start, .in_luma, .in_u, .in_v, .out_valid, .out_ready,
    .out_luma, .out_u, .out_v
  );

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Sampled mid-cycle, so the handshake seen is the one the edge takes
  always @(negedge clk_sys) begin
    if (!reset && clk_en && out_valid && out_ready)
      got_q.push_back({out_luma, out_u, out_v});
  end

  task automatic check(input string what, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Leading edge leaves one idle cycle, so no signal is set twice a step
  task automatic apb(input logic w, input logic [11:0] i,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    logic ok;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1;
    ok = 0;
    while (!ok) begin
      @(posedge clk_sys);
      ok = pready;
      r = prdata;
      e = pslverr;
    end
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask

  task automatic rd(input logic [11:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, i, 8'h00, r, e);
    check("prdata", r, x);
  endtask

  // Gain with floor shift and clamp, then coring
  function automatic logic [7:0] adj(input logic [7:0] x, input int g);
    int p;
    p = ($signed(x) * g) >>> 7;
    if (p > 127) p = 127;
    if (p < -128) p = -128;
    if (p <= thr && p >= -thr) p = 0;
    return p[7:0];
  endfunction

  // Two-tap chroma low-pass: signed mean, rounded down
  function automatic logic [7:0] lpf(input logic [7:0] a, b);
    logic signed [8:0] s;
    s = $signed({a[7], a}) + $signed({b[7], b});
    return (lp != 0) ? s[8:1] : a;
  endfunction

  task automatic pix;
    int          k;
    int          j;
    logic        ok;
    k = n_in;
    j = k - 2 - dly;
    hy[k] = 8'(k * 5 + 1);
    hu[k] = 8'(k * 37);
    hv[k] = 8'(192 + k * 11);
    @(posedge clk_sys);
    in_valid <= 1;
    in_line_start <= (k == 0);
    in_luma <= hy[k];
    in_u <= hu[k];
    in_v <= hv[k];
    ok = 0;
    while (!ok) begin
      @(posedge clk_sys);
      ok = in_ready;
    end
    in_valid <= 0;
    exp_q.push_back({k >= 2 ? hy[k - 2] : 8'h00,
      adj(lpf(j >= 0 ? hu[j] : 8'h00, j >= 1 ? hu[j - 1] : 8'h00), ug),
      adj(lpf(j >= 0 ? hv[j] : 8'h00, j >= 1 ? hv[j - 1] : 8'h00), vg)});
    n_in++;
  endtask

  task automatic batch(input int d, input logic [2:0] dc, input int c);
    dly = d;
    thr = THR[c];
    wr(vsca_pkg::IDX_CCTL, {2'b00, lp[0], dc, 2'(c)});
    @(posedge clk_sys);
    out_ready <= 0;
    pix();
    pix();
    @(negedge clk_sys);
    check("in_ready", 32'(in_ready), 32'h0);
    @(posedge clk_sys);
    out_ready <= 1;
    repeat (6) pix();
    repeat (4) @(posedge clk_sys);
  endtask

  initial begin
    #300us;
    num_errors++;
    give_verdict();
  end

  initial begin
    reset = 1; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; field_odd = 0; video_std = 0; in_valid = 0;
    in_line_start = 0; in_luma = 0; in_u = 0; in_v = 0; out_ready = 1;
    num_errors = 0; cmp_count = 0; n_in = 0; dly = 0; thr = 0; lp = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    for (int i = 0; i < 12; i++)
      rd(B + 12'(i), (i == 8 || i == 9) ? 32'h80 : 32'h0);
    for (int i = 0; i < 12; i++) begin
      wr(B + 12'(i), 8'hff);
      rd(B + 12'(i), {24'h0, MASK[i]});
    end
    wr(B, 8'h12);
    wr(B + 12'h1, 8'h34);
    wr(B + 12'h2, 8'h56);
    @(negedge clk_sys);
    check("horiz_ratio", 32'(horiz_ratio), 32'h563412);
    wr(vsca_pkg::IDX_VFACT_LO, 8'hab);
    wr(vsca_pkg::IDX_VFACT_HI, 8'hf5);
    @(negedge clk_sys);
    check("vert_factor", 32'(vert_factor), 32'h15ab);
    for (int c = 0; c < 8; c++) begin
      wr(vsca_pkg::IDX_LUMA_LOWPASS_SELECT, 8'(c));
      wr(vsca_pkg::IDX_VERTICAL_TAP_SELECT, 8'(c));
      // Tap count is registered one edge after the write lands
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("luma_sel", 32'(luma_lowpass_select), c % 4);
      check("taps", 32'(vertical_tap_count), c < 4 ? c + 2 : 2);
    end
    for (int m = 0; m < 4; m++) begin
      wr(vsca_pkg::IDX_VERTICAL_TAP_SELECT, {4'h0, m[1], 3'h0});
      field_odd <= m[0];
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check("phase", 32'(vert_phase_odd), 32'(m == 3));
    end
    // Low enable must freeze the phase flag against a field change
    @(posedge clk_sys);
    clk_en <= 0;
    field_odd <= 0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("frozen", 32'(vert_phase_odd), 32'h1);
    @(posedge clk_sys);
    clk_en <= 1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("thawed", 32'(vert_phase_odd), 32'h0);
    rd(12'h424, 32'h0);
    wr(vsca_pkg::IDX_HUE, 8'h00);
    wr(vsca_pkg::IDX_UGAIN, 8'h40);
    wr(vsca_pkg::IDX_VGAIN, 8'hff);
    ug = 64;
    vg = 255;
    for (int i = 0; i < 5; i++)
      batch(i - 2, 3'(i - 2), i % 4);
    lp = 1;
    batch(2, 3'b010, 1);
    lp = 0;
    video_std <= vsca_pkg::STD_SECAM;
    wr(vsca_pkg::IDX_HUE, 8'h40);
    batch(0, 3'b011, 0);
    check("out_count", 32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size()) check("pixel", 32'(got_q[i]), 32'(exp_q[i]));
    give_verdict();
  end
endmodule // tb_video_scaler_chroma_adjust
